// [src/sscd_slot_ctrl.sv]
// Slot power and state control registers with debounce counters and timing clock select.
//
// Notes on behaviour
// - Regulator bit powers slot LDO, releases pull-down.
// - Voltage bit picks 1.8 V or 2.95 V.
// - State 00: off pull-downs or totem pull-down.
// - State 01 isolates, outputs latched, totem driven.
// - State 11 active, card outputs follow host.
// - State and regulator bits stay independent.
// - Battery debounce count; zero means no debounce.
// - Shutdown debounce count; zero means bypass.
// - Writing count restarts a running counter.
// - New count acts within one timing tick.
// - Clock bit 7 selects internal or external.
// - Status shows powered down whenever regulator off.
// - Battery absent only after debounce expires.
`timescale 1ns/1ps
`include "sscd_defines.svh"
module sscd_slot_ctrl #(
  parameter int TICK_CYCLES = `SSCD_TICK_CYCLES // System cycles per internal timing tick.
) (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_arst_n,
  // Internal register port, driven by the serial control slave.
  input wire logic i_reg_wr_en,
  input wire logic i_reg_rd_en,
  input wire logic [7:0] i_reg_addr,
  input wire sscd_pkg::sscd_byte_t i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rd_valid,
  // Pins from outside the clock domain.
  input wire logic i_ext_timing_clock,
  input wire logic i_battery_presence_input,
  input wire logic i_shutdown_input,
  input wire logic i_host_card_reset,
  input wire logic i_host_card_clock,
  // Per-slot regulator controls; index 0 is card_slot_one, index 1 card_slot_two.
  output logic [1:0] o_ldo_enable,
  output logic [1:0] o_ldo_out_pulldown,
  output logic [1:0] o_ldo_volt_high,
  // Per-slot interface stage controls.
  output logic [1:0] o_if_pulldown_resistor,
  output logic [1:0] o_if_totem_drive,
  output sscd_pkg::sscd_slot_status_t o_card_slot_one_status,
  output sscd_pkg::sscd_slot_status_t o_card_slot_two_status,
  // Card-side outputs.
  output logic [1:0] o_card_reset,
  output logic [1:0] o_card_clock,
  // Debounced detection results.
  output logic o_battery_absent,
  output logic o_shutdown_level
);
  import sscd_pkg::*;

  // Register state.
  sscd_byte_t slot_ctrl_r; // Slot power and state control.
  sscd_byte_t slot_ctrl_nxt;
  sscd_byte_t batt_deb_r; // Battery presence debounce count.
  sscd_byte_t batt_deb_nxt;
  sscd_byte_t sdn_deb_r; // Shutdown input debounce count.
  sscd_byte_t sdn_deb_nxt;
  sscd_byte_t clk_sel_r; // Timing clock source; low bits reserved.
  sscd_byte_t clk_sel_nxt;
  logic [7:0] rdata_r; // Read data held until the next read.
  logic [7:0] rdata_nxt;
  logic rd_valid_r; // One-cycle read answer.
  logic rd_valid_nxt;
  logic batt_restart; // Write strobe to the battery count.
  logic sdn_restart; // Write strobe to the shutdown count.

  // Pin synchronisers: three stages; filtered level moves when stages two and three agree.
  logic [2:0] ext_sync_r;
  logic [2:0] batt_sync_r;
  logic [2:0] sdn_sync_r;
  logic [2:0] hrst_sync_r;
  logic [2:0] hclk_sync_r;
  logic [4:0] filt_r; // Filtered levels: ext, batt, sdn, hrst, hclk.
  logic [4:0] filt_nxt;
  logic ext_level_d_r; // Previous filtered external clock, for edge detection.

  // Timing tick generation.
  logic [15:0] div_r; // Internal divider count.
  logic [15:0] div_nxt;
  logic int_tick; // Internal timing tick.
  logic ext_tick; // External clock rising edge.
  logic timing_tick; // Selected timing tick.

  // Register writes; every written bit is stored as given, state 10 included.
  always_comb begin
    slot_ctrl_nxt = slot_ctrl_r;
    batt_deb_nxt = batt_deb_r;
    sdn_deb_nxt = sdn_deb_r;
    clk_sel_nxt = clk_sel_r;
    batt_restart = 1'b0;
    sdn_restart = 1'b0;
    if (i_reg_wr_en) begin
      if (i_reg_addr == `SSCD_ADDR_SLOT_CTRL) begin
        // Stored verbatim: no hardware block on state 10.
        slot_ctrl_nxt = i_reg_wdata;
      end else if (i_reg_addr == `SSCD_ADDR_BATT_DEB) begin
        batt_deb_nxt = i_reg_wdata;
        batt_restart = 1'b1;
      end else if (i_reg_addr == `SSCD_ADDR_SDN_DEB) begin
        sdn_deb_nxt = i_reg_wdata;
        sdn_restart = 1'b1;
      end else if (i_reg_addr == `SSCD_ADDR_CLK_SEL) begin
        clk_sel_nxt = i_reg_wdata; // Reserved bits kept as plain storage.
      end
    end
  end

  // Reads answer one cycle later; unmapped offsets read as zero.
  always_comb begin
    rdata_nxt = rdata_r;
    rd_valid_nxt = i_reg_rd_en;
    if (i_reg_rd_en) begin
      if (i_reg_addr == `SSCD_ADDR_SLOT_CTRL) begin
        rdata_nxt = slot_ctrl_r;
      end else if (i_reg_addr == `SSCD_ADDR_BATT_DEB) begin
        rdata_nxt = batt_deb_r;
      end else if (i_reg_addr == `SSCD_ADDR_SDN_DEB) begin
        rdata_nxt = sdn_deb_r;
      end else if (i_reg_addr == `SSCD_ADDR_CLK_SEL) begin
        rdata_nxt = clk_sel_r;
      end else begin
        rdata_nxt = `SSCD_RST_RDATA;
      end
    end
  end

  // Register bank flip-flops.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      slot_ctrl_r <= `SSCD_RST_SLOT_CTRL;
      batt_deb_r <= `SSCD_RST_BATT_DEB;
      sdn_deb_r <= `SSCD_RST_SDN_DEB;
      clk_sel_r <= `SSCD_RST_CLK_SEL;
      rdata_r <= `SSCD_RST_RDATA;
      rd_valid_r <= 1'b0;
    end else begin
      slot_ctrl_r <= slot_ctrl_nxt;
      batt_deb_r <= batt_deb_nxt;
      sdn_deb_r <= sdn_deb_nxt;
      clk_sel_r <= clk_sel_nxt;
      rdata_r <= rdata_nxt;
      rd_valid_r <= rd_valid_nxt;
    end
  end

  assign o_reg_rdata = rdata_r;
  assign o_reg_rd_valid = rd_valid_r;

  // Filtered levels follow stage three only when stages two and three agree.
  always_comb begin
    filt_nxt = filt_r;
    if (ext_sync_r[1] == ext_sync_r[2]) begin
      filt_nxt[4] = ext_sync_r[2];
    end
    if (batt_sync_r[1] == batt_sync_r[2]) begin
      filt_nxt[3] = batt_sync_r[2];
    end
    if (sdn_sync_r[1] == sdn_sync_r[2]) begin
      filt_nxt[2] = sdn_sync_r[2];
    end
    if (hrst_sync_r[1] == hrst_sync_r[2]) begin
      filt_nxt[1] = hrst_sync_r[2];
    end
    if (hclk_sync_r[1] == hclk_sync_r[2]) begin
      filt_nxt[0] = hclk_sync_r[2];
    end
  end

  // Synchroniser chains; stage one feeds only stage two.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ext_sync_r <= 3'h0;
      batt_sync_r <= 3'h7;
      sdn_sync_r <= 3'h0;
      hrst_sync_r <= 3'h0;
      hclk_sync_r <= 3'h0;
      filt_r <= 5'h08;
      ext_level_d_r <= 1'b0;
    end else begin
      ext_sync_r <= {ext_sync_r[1:0], i_ext_timing_clock};
      batt_sync_r <= {batt_sync_r[1:0], i_battery_presence_input};
      sdn_sync_r <= {sdn_sync_r[1:0], i_shutdown_input};
      hrst_sync_r <= {hrst_sync_r[1:0], i_host_card_reset};
      hclk_sync_r <= {hclk_sync_r[1:0], i_host_card_clock};
      filt_r <= filt_nxt;
      ext_level_d_r <= filt_r[4];
    end
  end

  // Internal timing divider; stands in for the on-chip 32 kHz source.
  always_comb begin
    int_tick = (div_r == 16'(TICK_CYCLES - 1));
    div_nxt = int_tick ? 16'h0000 : div_r + 16'h0001;
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_nxt;
    end
  end

  // Source select: internal divider at 0, external pin edges at 1.
  assign ext_tick = filt_r[4] & ~ext_level_d_r;
  assign timing_tick = clk_sel_r[`SSCD_BIT_CLK_SRC] ? ext_tick : int_tick;

  // Debounce counters for battery presence and shutdown.
  sscd_deb_if batt_if ();
  sscd_deb_if sdn_if ();

  assign batt_if.tick = timing_tick;
  assign batt_if.raw = filt_r[3];
  assign batt_if.count = batt_deb_r;
  assign batt_if.restart = batt_restart;
  assign sdn_if.tick = timing_tick;
  assign sdn_if.raw = filt_r[2];
  assign sdn_if.count = sdn_deb_r;
  assign sdn_if.restart = sdn_restart;

  sscd_debounce #(.RESET_LEVEL(1'b1)) u_batt_deb (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .deb(batt_if)
  );

  sscd_debounce #(.RESET_LEVEL(1'b0)) u_sdn_deb (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .deb(sdn_if)
  );

  // Battery absence is reported only from the debounced level.
  assign o_battery_absent = ~batt_if.stable;
  assign o_shutdown_level = sdn_if.stable;

  // Per-slot decode and card-side output stage.
  sscd_slot_status_t slot_status [1:0];

  for (genvar s = 0; s < 2; s++) begin : g_slot
    logic reg_on; // Regulator enable bit of this slot.
    logic [1:0] st; // Written state field of this slot.
    logic [1:0] card_r; // Card reset and clock outputs.
    logic [1:0] card_nxt;

    assign reg_on = slot_ctrl_r[s * `SSCD_SLOT_STRIDE + `SSCD_BIT_REG_ON];
    assign st = slot_ctrl_r[s * `SSCD_SLOT_STRIDE + `SSCD_BIT_STATE_LO +: 2];

    // Regulator on/off and output pull-down release.
    assign o_ldo_enable[s] = reg_on;
    assign o_ldo_out_pulldown[s] = ~reg_on;
    // Output voltage select: 0 low, 1 high.
    assign o_ldo_volt_high[s] = slot_ctrl_r[s * `SSCD_SLOT_STRIDE + `SSCD_BIT_VSEL];

    // Status merges the state field with the regulator bit; code 00 with the regulator
    // on is reported as powered, since only the totem stage pulls the lines low.
    assign slot_status[s] = !reg_on ? SSCD_ST_DOWN
                            : (st == `SSCD_STATE_OFF) ? SSCD_ST_POWERED
                            : sscd_slot_status_t'(st);

    // Pull-down resistors only while the regulator is off, or in the forbidden
    // powered code; code 00 with the regulator on relies on the totem stage instead.
    assign o_if_pulldown_resistor[s] = !reg_on
                                       || (st == `SSCD_STATE_PWR);
    // Totem stage drives in isolated-low, isolated-latched and active.
    assign o_if_totem_drive[s] = reg_on && (st != `SSCD_STATE_PWR);

    // Card-side output values per slot condition.
    always_comb begin
      card_nxt = card_r;
      if (!reg_on || st == `SSCD_STATE_OFF || st == `SSCD_STATE_PWR) begin
        // Powered down or isolated with pull-down: outputs low.
        card_nxt = 2'b00;
      end else if (st == `SSCD_STATE_ACT) begin
        // Active: outputs track the host-side inputs.
        card_nxt = filt_r[1:0];
      end else begin
        // Isolated: hold the last level.
        card_nxt = card_r;
      end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
        card_r <= 2'b00;
      end else begin
        card_r <= card_nxt;
      end
    end

    assign o_card_reset[s] = card_r[1];
    assign o_card_clock[s] = card_r[0];
  end

  assign o_card_slot_one_status = slot_status[0];
  assign o_card_slot_two_status = slot_status[1];

endmodule : sscd_slot_ctrl

// [common/sscd_defines.svh]
// Offsets, field positions, reset values and timing counts of the slot control bank.
`ifndef SSCD_DEFINES_SVH
`define SSCD_DEFINES_SVH

// Register offsets on the internal register port.
`define SSCD_ADDR_SLOT_CTRL 8'h08
`define SSCD_ADDR_BATT_DEB 8'h0a
`define SSCD_ADDR_SDN_DEB 8'h0b
`define SSCD_ADDR_CLK_SEL 8'h0d

// Reset values.
`define SSCD_RST_SLOT_CTRL 8'h00
`define SSCD_RST_BATT_DEB 8'h04
`define SSCD_RST_SDN_DEB 8'h04
`define SSCD_RST_CLK_SEL 8'h00
`define SSCD_RST_RDATA 8'h00

// Field positions inside the slot control register; slot two adds the stride. The clock source bit is in the clock select register.
`define SSCD_SLOT_STRIDE 4
`define SSCD_BIT_REG_ON 0
`define SSCD_BIT_VSEL 1
`define SSCD_BIT_STATE_LO 2
`define SSCD_BIT_CLK_SRC 7

// Slot state codes.
`define SSCD_STATE_OFF 2'b00
`define SSCD_STATE_ISO 2'b01
`define SSCD_STATE_PWR 2'b10
`define SSCD_STATE_ACT 2'b11

// Timing: system clock and nominal 32 kHz timing clock periods.
`define SSCD_CLOCK_PERIOD_NS 100
`define SSCD_TIMING_PERIOD_NS 31250
`define SSCD_TICK_CYCLES (`SSCD_TIMING_PERIOD_NS / `SSCD_CLOCK_PERIOD_NS)

`endif

// [common/sscd_pkg.sv]
// Types shared by the slot control bank and its debounce counter.
package sscd_pkg;

  // Decoded condition of one card slot, as reported in status.
  typedef enum logic [1:0] {
    SSCD_ST_DOWN = 2'b00,
    SSCD_ST_ISOLATED = 2'b01,
    SSCD_ST_POWERED = 2'b10,
    SSCD_ST_ACTIVE = 2'b11
  } sscd_slot_status_t;

  // Eight-bit register value.
  typedef logic [7:0] sscd_byte_t;

endpackage : sscd_pkg

// [common/sscd_deb_if.sv]
// Carrier between the register bank and one debounce counter.
`timescale 1ns/1ps
interface sscd_deb_if;
  import sscd_pkg::*;
  logic tick; // One-cycle pulse per timing clock period.
  logic raw; // Synchronised input level.
  sscd_byte_t count; // Programmed debounce count.
  logic restart; // One-cycle pulse when the count register is written.
  logic stable; // Debounced level.

  modport ctrl (output tick, output raw, output count, output restart, input stable);
  modport deb (input tick, input raw, input count, input restart, output stable);
endinterface : sscd_deb_if

// [src/sscd_debounce.sv]
// Debounce counter for one slow input, stepped by the timing clock tick.
`timescale 1ns/1ps
module sscd_debounce #(
  parameter logic RESET_LEVEL = 1'b1 // Level assumed before the first sample.
) (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_arst_n,
  // Link to the register bank.
  sscd_deb_if.deb deb
);
  import sscd_pkg::*;

  sscd_byte_t cnt_r; // Timing ticks seen while the input differs.
  sscd_byte_t cnt_nxt;
  logic stable_r; // Declared level.
  logic stable_nxt;

  // Next-state logic; the live count is compared, so a new value acts at once.
  always_comb begin
    cnt_nxt = cnt_r;
    stable_nxt = stable_r;
    if (deb.count == 8'h00) begin
      // A zero count passes the input straight through.
      stable_nxt = deb.raw;
      cnt_nxt = 8'h00;
    end else if (deb.raw == stable_r) begin
      // The input reverted, so the run is abandoned.
      cnt_nxt = 8'h00;
    end else if (deb.restart) begin
      // A count write during a run starts it again with the new value.
      cnt_nxt = 8'h00;
    end else if (deb.tick) begin
      if ({1'b0, cnt_r} + 9'h001 >= {1'b0, deb.count}) begin
        // Count reached: the new level is declared.
        stable_nxt = deb.raw;
        cnt_nxt = 8'h00;
      end else begin
        cnt_nxt = cnt_r + 8'h01;
      end
    end
  end

  // State registers.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_r <= 8'h00;
      stable_r <= RESET_LEVEL;
    end else begin
      cnt_r <= cnt_nxt;
      stable_r <= stable_nxt;
    end
  end

  assign deb.stable = stable_r;

endmodule : sscd_debounce

// [verif/sscd_baseband_model.sv]
// Baseband side model: host card signals and a gated external timing clock.
`timescale 1ns/1ps
module sscd_baseband_model (
  // Clock, reset and commands from the bench.
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_card_clock_run,
  input wire logic i_ext_clock_run,
  input wire logic i_card_reset_level,
  // Pins toward the device.
  output logic o_host_card_reset,
  output logic o_host_card_clock,
  output logic o_ext_timing_clock
);
  logic [3:0] div_r; // Shared divider, so both clocks run at a sixteenth of the system rate.
  logic [3:0] div_nxt; // Next divider value.
  // The divider only counts; it is slow enough for the pin synchronisers.
  always_comb begin
    div_nxt = div_r + 4'h1;
  end
  // Divider register.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_r <= 4'h0;
    end else begin
      div_r <= div_nxt;
    end
  end
  // Clocks stand still at 0 outside their runs, as a real host leaves them.
  assign o_host_card_clock = i_card_clock_run & div_r[3];
  assign o_ext_timing_clock = i_ext_clock_run & div_r[3];
  assign o_host_card_reset = i_card_reset_level;
endmodule : sscd_baseband_model

// [verif/sscd_slot_ctrl_sva.sv]
// Concurrent checks on the ports of the slot control bank.
`timescale 1ns/1ps
module sscd_slot_ctrl_sva
  import sscd_pkg::*;
(
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_arst_n,
  // Register port.
  input wire logic i_reg_wr_en,
  input wire logic i_reg_rd_en,
  input wire logic [7:0] i_reg_addr,
  input wire sscd_pkg::sscd_byte_t i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  // Slot outputs.
  input wire logic [1:0] o_ldo_enable,
  input wire logic [1:0] o_ldo_out_pulldown,
  input wire logic [1:0] o_ldo_volt_high,
  input wire logic [1:0] o_if_pulldown_resistor,
  input wire logic [1:0] o_if_totem_drive,
  input wire sscd_pkg::sscd_slot_status_t o_card_slot_one_status,
  input wire sscd_pkg::sscd_slot_status_t o_card_slot_two_status
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  logic slot_wr; // A write to the slot control byte.
  sscd_byte_t wd_r, wd2_r, wd3_r; // Write data delayed one, two and three cycles.
  logic [7:0] ad_r, ad2_r; // Address delayed one and two cycles.
  assign slot_wr = i_reg_wr_en && i_reg_addr == 8'h08;
  // Delay lines let a consequent see the data of its antecedent cycle.
  always_ff @(posedge i_clock) begin
    wd_r <= i_reg_wdata;
    wd2_r <= wd_r;
    wd3_r <= wd2_r;
    ad_r <= i_reg_addr;
    ad2_r <= ad_r;
  end
  property p_ldo_on;
    slot_wr |=> o_ldo_enable == {wd_r[4], wd_r[0]};
  endproperty
  a_ldo_on: assert property (p_ldo_on) else $error("regulator enable wrong");
  property p_ldo_pd;
    o_ldo_out_pulldown == ~o_ldo_enable;
  endproperty
  a_ldo_pd: assert property (p_ldo_pd) else $error("regulator pull-down wrong");
  property p_vsel;
    slot_wr |=> o_ldo_volt_high == {wd_r[5], wd_r[1]};
  endproperty
  a_vsel: assert property (p_vsel) else $error("voltage select wrong");
  property p_off_pd;
    slot_wr && !i_reg_wdata[4] |=> o_if_pulldown_resistor[1] && !o_if_totem_drive[1];
  endproperty
  a_off_pd: assert property (p_off_pd) else $error("powered down stage wrong");
  property p_iso_act;
    slot_wr && i_reg_wdata[0] && i_reg_wdata[2] |=> o_if_totem_drive[0] && !o_if_pulldown_resistor[0];
  endproperty
  a_iso_act: assert property (p_iso_act) else $error("isolated or active stage wrong");
  property p_st1;
    slot_wr |=> o_card_slot_one_status
      == (!wd_r[0] ? 2'b00 : (wd_r[3:2] == 2'b00) ? 2'b10 : wd_r[3:2]);
  endproperty
  a_st1: assert property (p_st1) else $error("slot one status wrong");
  property p_st2;
    slot_wr |=> o_card_slot_two_status
      == (!wd_r[4] ? 2'b00 : (wd_r[7:6] == 2'b00) ? 2'b10 : wd_r[7:6]);
  endproperty
  a_st2: assert property (p_st2) else $error("slot two status wrong");
  property p_rdback;
    i_reg_wr_en && i_reg_addr inside {8'h08, 8'h0a, 8'h0b, 8'h0d} ##1 !i_reg_wr_en
      ##1 i_reg_rd_en && i_reg_addr == ad2_r |=> o_reg_rdata == wd3_r;
  endproperty
  a_rdback: assert property (p_rdback) else $error("read back wrong");
endmodule : sscd_slot_ctrl_sva
bind sscd_slot_ctrl sscd_slot_ctrl_sva sscd_slot_ctrl_sva_i (.i_clock(i_clock),
  .i_arst_n(i_arst_n), .i_reg_wr_en(i_reg_wr_en), .i_reg_rd_en(i_reg_rd_en),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .o_ldo_enable(o_ldo_enable), .o_ldo_out_pulldown(o_ldo_out_pulldown),
  .o_ldo_volt_high(o_ldo_volt_high), .o_if_pulldown_resistor(o_if_pulldown_resistor),
  .o_if_totem_drive(o_if_totem_drive), .o_card_slot_one_status(o_card_slot_one_status),
  .o_card_slot_two_status(o_card_slot_two_status));

// [verif/sim_slot_control_debounce_regs_tb_top.sv]
// Self-checking bench for the slot control bank.
`timescale 1ns/1ps
module sim_slot_control_debounce_regs_tb_top;
  import sscd_pkg::*;
  logic i_clock = 1'b0; // System clock.
  logic i_arst_n = 1'b0; // Reset, low at start.
  logic wr_en = 1'b0, rd_en = 1'b0, rd_valid, batt = 1'b1, shutdown_input = 1'b0;
  logic card_run = 1'b0, ext_run = 1'b0, rst_lvl = 1'b0, host_rst, host_clk, ext_clk;
  logic [7:0] addr = 8'h00, rdata;
  sscd_byte_t wdata = 8'h00;
  logic [1:0] ldo_en, ldo_pd, volt, pdr, totem, card_rst, card_clk;
  sscd_slot_status_t st1, st2;
  logic absent, sdn_lvl;
  logic [3:0] obs; // Levels that the bounded waits watch.
  int err_count = 0;
  int comparisons = 0;
  logic [7:0] ra [5] = '{8'h08, 8'h0a, 8'h0b, 8'h0d, 8'h09}; // Includes an unmapped offset.
  logic [7:0] rv [5] = '{8'h00, 8'h04, 8'h04, 8'h00, 8'h00};
  logic [7:0] sv [6] = '{8'h1d, 8'h27, 8'hd0, 8'h4e, 8'h75, 8'h00}; // Never state code 10.
  assign obs = {card_clk[0], card_rst[0], sdn_lvl, absent};
  // Half of the 100 ns period.
  always #50 i_clock = ~i_clock;
  // Short tick keeps the debounce runs brief.
  sscd_slot_ctrl #(.TICK_CYCLES(4)) sscd_slot_ctrl_i (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_reg_wr_en(wr_en), .i_reg_rd_en(rd_en), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .o_reg_rd_valid(rd_valid), .i_ext_timing_clock(ext_clk),
    .i_battery_presence_input(batt), .i_shutdown_input(shutdown_input), .i_host_card_reset(host_rst),
    .i_host_card_clock(host_clk), .o_ldo_enable(ldo_en), .o_ldo_out_pulldown(ldo_pd),
    .o_ldo_volt_high(volt), .o_if_pulldown_resistor(pdr), .o_if_totem_drive(totem),
    .o_card_slot_one_status(st1), .o_card_slot_two_status(st2), .o_card_reset(card_rst),
    .o_card_clock(card_clk), .o_battery_absent(absent), .o_shutdown_level(sdn_lvl));
  sscd_baseband_model sscd_baseband_model_i (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_card_clock_run(card_run), .i_ext_clock_run(ext_run), .i_card_reset_level(rst_lvl),
    .o_host_card_reset(host_rst), .o_host_card_clock(host_clk), .o_ext_timing_clock(ext_clk));
  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk
  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  // One write strobe; returns just after the taking edge, so fields have settled.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge i_clock);
    wr_en <= 1'b0;
    #1;
  endtask : wr
  // One read strobe; the answer is awaited under a bound.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    int n;
    @(posedge i_clock);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge i_clock);
    rd_en <= 1'b0;
    #1;
    for (n = 0; n < 4 && rd_valid !== 1'b1; n++) begin
      @(posedge i_clock);
      #1;
    end
    chk({7'h0, rd_valid}, 8'h01);
    chk(rdata, exp);
    if (rd_valid !== 1'b1) results();
  endtask : rd
  // Waits a bounded number of cycles for a watched level.
  task automatic wt(input int k, input logic v, input int lim);
    int n;
    for (n = 0; n < lim && obs[k] !== v; n++) begin
      @(posedge i_clock);
      #1;
    end
    chk({7'h0, obs[k]}, {7'h0, v});
    if (obs[k] !== v) results();
  endtask : wt
  // Lets a fixed number of cycles pass.
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : cyc
  // Main sequence.
  initial begin : main
    logic [7:0] v;
    repeat (4) @(posedge i_clock);
    i_arst_n <= 1'b1;
    foreach (ra[i]) rd(ra[i], rv[i]);
    foreach (sv[i]) begin
      v = sv[i];
      wr(8'h08, v);
      chk(ldo_en, {v[4], v[0]});
      chk(ldo_pd, {~v[4], ~v[0]});
      chk(volt, {v[5], v[1]});
      chk(pdr, {~v[4], ~v[0]});
      chk(totem, {v[4], v[0]});
      chk(st1, !v[0] ? 2'b00 : (v[3:2] == 2'b00) ? 2'b10 : v[3:2]);
      chk(st2, !v[4] ? 2'b00 : (v[7:6] == 2'b00) ? 2'b10 : v[7:6]);
      rd(8'h08, v);
    end
    @(posedge i_clock) rst_lvl <= 1'b1;
    card_run <= 1'b1;
    wr(8'h08, 8'hdd);
    wt(2, 1'b1, 12);
    chk(card_rst, 2'b11);
    wt(3, 1'b1, 40);
    wr(8'h08, 8'h05);
    @(posedge i_clock) rst_lvl <= 1'b0;
    cyc(20);
    chk(card_rst[0], 1'b1);
    chk(card_rst, 2'b01);
    wr(8'h08, 8'h00);
    wt(2, 1'b0, 12);
    @(posedge i_clock) batt <= 1'b0;
    cyc(10);
    chk(absent, 1'b0);
    wt(0, 1'b1, 40);
    wr(8'h0a, 8'h00);
    @(posedge i_clock) batt <= 1'b1;
    wt(0, 1'b0, 7);
    wr(8'h0b, 8'h00);
    @(posedge i_clock) shutdown_input <= 1'b1;
    wt(1, 1'b1, 7);
    wr(8'h0b, 8'h20);
    @(posedge i_clock) shutdown_input <= 1'b0;
    cyc(60);
    wr(8'h0b, 8'h20);
    cyc(88);
    chk(sdn_lvl, 1'b1);
    wt(1, 1'b0, 100);
    wr(8'h0a, 8'h02);
    wr(8'h0d, 8'h80);
    @(posedge i_clock) batt <= 1'b0;
    cyc(100);
    chk(absent, 1'b0);
    @(posedge i_clock) ext_run <= 1'b1;
    wt(0, 1'b1, 80);
    @(posedge i_clock) ext_run <= 1'b0;
    wr(8'h0d, 8'h7f);
    rd(8'h0d, 8'h7f);
    @(posedge i_clock) batt <= 1'b1;
    wt(0, 1'b0, 30);
    results();
  end
endmodule : sim_slot_control_debounce_regs_tb_top
